// ==== src/mjo_judge_top.v ====
// Measurement error substitution and switching output judgment with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "mjo_map.vh"
module mjo_judge_top #(
  parameter TICK_CYC = `MJO_TICK_NS / `MJO_CLK_NS
) (
  input wire ref_clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire meas_valid,
  input wire signed [31:0] meas_value,
  input wire meas_alarm,
  input wire [15:0] light_level,
  output reg signed [31:0] out_value,
  output wire switch_output_one
);
  localparam [1:0] ERR_CLAMP = 2'h0;
  localparam [1:0] ERR_HOLD = 2'h1;
  localparam [1:0] ERR_HOLDT = 2'h2;
  localparam [2:0] MD_ONE = 3'h0;
  localparam [2:0] MD_ZONE = 3'h1;
  localparam [2:0] MD_TOL = 3'h2;
  localparam [2:0] MD_NOMEAS = 3'h3;
  localparam [2:0] MD_LIGHT = 3'h4;
  localparam [2:0] MD_EDGE = 3'h5;
  localparam [1:0] DIR_POS = 2'h0;
  localparam [1:0] DIR_NEG = 2'h1;
  localparam [1:0] DIR_BOTH = 2'h2;

  // Byte-lane merge for partial writes
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer i;
    begin
      wmerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          wmerge[i*8 +: 8] = dat[i*8 +: 8];
        end
      end
    end
  endfunction

  // Magnitude of a signed length
  function [31:0] mag;
    input signed [31:0] x;
    begin
      mag = x[31] ? (~x + 32'h1) : x;
    end
  endfunction

  reg [31:0] ctrl_r;
  reg signed [31:0] clamp_r;
  reg [16:0] hold_ms_r;
  reg signed [31:0] thr1_r;
  reg signed [31:0] thr2_r;
  reg signed [31:0] hyst_r;
  reg signed [31:0] tol_r;
  reg [15:0] light_thr_r;
  reg [31:0] emin_r;
  reg [31:0] emax_r;
  reg [4:0] lag_r;
  reg [14:0] timer_ms_r;
  reg inval_r;
  reg tph_r;
  reg [31:0] tick_cnt_r;
  reg ms_tick_r;
  reg alarm_r;
  reg signed [31:0] last_good_r;
  reg [16:0] hold_cnt_r;
  reg in_r;
  reg judge_r;
  reg edge_hit_r;
  reg signed [31:0] edge_held_r;
  reg signed [31:0] hist [0:31];
  reg [4:0] wp_r;
  reg [4:0] fill_r;
  reg [31:0] rd_word;

  wire [1:0] err_mode = ctrl_r[`MJO_F_ERR];
  wire [2:0] out_mode = ctrl_r[`MJO_F_MODE];
  wire far_on = ctrl_r[`MJO_F_FAR];
  wire [2:0] dly_mode = ctrl_r[`MJO_F_DLY];
  wire [1:0] edge_dir = ctrl_r[`MJO_F_DIR];
  wire dir_rev = ctrl_r[`MJO_F_REV];
  wire edge_hold = ctrl_r[`MJO_F_EHOLD];
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i;
  wire [31:0] wdat;

  // Merged write word shared by every setting register and its range check; the STAT clear and CMD teach read wb_dat_i directly
  assign wdat = wmerge(rd_word, wb_dat_i, wb_sel_i);

  // Millisecond tick; the period is a parameter so simulation can shorten it
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYC - 1) begin
      tick_cnt_r <= 32'h0;
      ms_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
      ms_tick_r <= 1'b0;
    end
  end

  // Error substitution: the value presented while the alarm stands
  wire hold_exp = hold_cnt_r > hold_ms_r;
  wire cur_alarm = meas_valid ? meas_alarm : alarm_r;
  reg signed [31:0] sub_val;
  reg signed [31:0] value_nxt;
  always @* begin
    if (err_mode == ERR_HOLD) begin
      sub_val = last_good_r;
    end else if (err_mode == ERR_HOLDT && !hold_exp) begin
      sub_val = last_good_r;
    end else begin
      sub_val = clamp_r;
    end
    if (cur_alarm) begin
      value_nxt = sub_val;
    end else if (meas_valid) begin
      value_nxt = meas_value;
    end else begin
      value_nxt = out_value;
    end
  end

  // Hold timer restarts on every alarm rise because it is cleared while the alarm is low
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_r <= 1'b0;
      last_good_r <= 32'sh0;
      hold_cnt_r <= 17'h0;
      out_value <= `MJO_R_CLAMP;
    end else begin
      out_value <= value_nxt;
      if (meas_valid) begin
        alarm_r <= meas_alarm;
        if (!meas_alarm) begin
          last_good_r <= meas_value;
        end
      end
      if (!alarm_r) begin
        hold_cnt_r <= 17'h0;
      end else if (ms_tick_r && !hold_exp) begin
        hold_cnt_r <= hold_cnt_r + 17'h1;
      end
    end
  end

  // Edge value from the history ring; no result until enough samples exist
  wire [4:0] rd_idx = wp_r - lag_r;
  wire signed [31:0] edge_v = value_nxt - hist[rd_idx];
  wire [31:0] edge_mag = mag(edge_v);
  wire [1:0] eff_dir = (dir_rev && edge_dir != DIR_BOTH) ? (edge_dir ^ 2'h1) : edge_dir;
  wire dir_ok = (eff_dir == DIR_BOTH) || (eff_dir == DIR_POS && !edge_v[31]) ||
                (eff_dir == DIR_NEG && edge_v[31]);
  wire edge_hit = (fill_r >= lag_r) && dir_ok && edge_mag >= emin_r && edge_mag <= emax_r;

  always @(posedge ref_clk) begin
    if (meas_valid) begin
      hist[wp_r] <= value_nxt;
    end
  end

  // Threshold windows; zone limits are sorted so either teach order works
  wire signed [31:0] zlo = (thr1_r < thr2_r) ? thr1_r : thr2_r;
  wire signed [31:0] zhi = (thr1_r < thr2_r) ? thr2_r : thr1_r;
  wire [31:0] tol_dist = mag(value_nxt - thr1_r);
  reg in_nxt;
  reg raw_judge;
  always @* begin
    in_nxt = in_r;
    case (out_mode)
      MD_ONE: begin
        if (value_nxt >= thr1_r) in_nxt = 1'b1;
        else if (value_nxt < thr1_r - hyst_r) in_nxt = 1'b0;
      end
      MD_ZONE: begin
        if (value_nxt >= zlo && value_nxt <= zhi) in_nxt = 1'b1;
        else if (value_nxt < zlo - hyst_r || value_nxt > zhi + hyst_r) in_nxt = 1'b0;
      end
      MD_TOL: begin
        if (tol_dist <= tol_r) in_nxt = 1'b1;
        else if (tol_dist > tol_r + hyst_r) in_nxt = 1'b0;
      end
      default: in_nxt = 1'b0;
    endcase
    case (out_mode)
      MD_ONE, MD_ZONE: raw_judge = in_nxt;
      MD_TOL: raw_judge = !in_nxt;
      MD_NOMEAS: raw_judge = meas_alarm;
      MD_LIGHT: raw_judge = light_level < light_thr_r;
      MD_EDGE: raw_judge = edge_hit;
      default: raw_judge = 1'b0;
    endcase
  end

  // Judgments step only on a sample strobe
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      in_r <= 1'b0;
      judge_r <= 1'b0;
      edge_hit_r <= 1'b0;
      edge_held_r <= 32'sh0;
      wp_r <= 5'h0;
      fill_r <= 5'h0;
    end else if (meas_valid) begin
      in_r <= in_nxt;
      judge_r <= raw_judge ^ far_on;
      edge_hit_r <= edge_hit;
      wp_r <= wp_r + 5'h1;
      if (fill_r != 5'h1f) fill_r <= fill_r + 5'h1;
      if (!edge_hold || (edge_hit && !edge_hit_r)) begin
        edge_held_r <= edge_v;
      end
    end
  end

  mjo_out_timer u_tmr (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ms_tick(ms_tick_r),
    .judge(judge_r),
    .dly_mode(dly_mode),
    .time_ms(timer_ms_r),
    .out_q(switch_output_one)
  );

  // Register read mux, also the base of partial writes; a process, so any register change is seen at once
  always @* begin
    case (wb_adr_i)
      `MJO_A_CTRL: rd_word = ctrl_r;
      `MJO_A_CLAMP: rd_word = clamp_r;
      `MJO_A_HOLD: rd_word = {15'h0, hold_ms_r};
      `MJO_A_THR1: rd_word = thr1_r;
      `MJO_A_THR2: rd_word = thr2_r;
      `MJO_A_HYST: rd_word = hyst_r;
      `MJO_A_TOL: rd_word = tol_r;
      `MJO_A_LIGHT: rd_word = {16'h0, light_thr_r};
      `MJO_A_EMIN: rd_word = emin_r;
      `MJO_A_EMAX: rd_word = emax_r;
      `MJO_A_LAG: rd_word = {27'h0, lag_r};
      `MJO_A_TIMER: rd_word = {17'h0, timer_ms_r};
      `MJO_A_STAT: rd_word = {27'h0, tph_r, inval_r, alarm_r, judge_r, switch_output_one};
      `MJO_A_VALUE: rd_word = out_value;
      `MJO_A_EDGE: rd_word = edge_held_r;
      default: rd_word = 32'h0;
    endcase
  end

  // Range check per register; a failed check leaves the old value in place
  reg wr_ok;
  always @* begin
    case (wb_adr_i)
      `MJO_A_CTRL: wr_ok = wdat[`MJO_F_ERR] <= ERR_HOLDT && wdat[`MJO_F_MODE] <= MD_EDGE &&
                           wdat[`MJO_F_DLY] <= 3'h4 && wdat[`MJO_F_DIR] <= DIR_BOTH;
      `MJO_A_CLAMP: wr_ok = $signed(wdat) >= `MJO_CLAMP_MIN && $signed(wdat) <= `MJO_CLAMP_MAX;
      `MJO_A_HOLD: wr_ok = wdat >= 32'h1 && wdat <= `MJO_HOLD_MAX;
      `MJO_A_TIMER: wr_ok = wdat >= 32'h1 && wdat <= `MJO_TIMER_MAX;
      `MJO_A_LAG: wr_ok = wdat >= 32'h1 && wdat <= `MJO_LAG_MAX;
      `MJO_A_LIGHT: wr_ok = wdat[31:16] == 16'h0;
      `MJO_A_HYST, `MJO_A_TOL, `MJO_A_EMIN, `MJO_A_EMAX: wr_ok = !wdat[31];
      default: wr_ok = 1'b1;
    endcase
  end

  wire teach = wb_wr && wb_adr_i == `MJO_A_CMD && wb_sel_i[0] && wb_dat_i[0];
  wire clr_inval = wb_wr && wb_adr_i == `MJO_A_STAT && wb_sel_i[0] && wb_dat_i[`MJO_S_INVAL];
  wire set_inval = wb_wr && !wr_ok;

  // Bus slave: one wait state, every address answers, unmapped reads zero
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_r <= `MJO_R_CTRL;
      clamp_r <= `MJO_R_CLAMP;
      hold_ms_r <= `MJO_R_HOLD;
      thr1_r <= 32'sh0;
      thr2_r <= 32'sh0;
      hyst_r <= 32'sh0;
      tol_r <= 32'sh0;
      light_thr_r <= `MJO_R_LIGHT;
      emin_r <= 32'h0;
      emax_r <= 32'h0;
      lag_r <= `MJO_R_LAG;
      timer_ms_r <= `MJO_R_TIMER;
      inval_r <= 1'b0;
      tph_r <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h0;
      // Set wins over a clear written in the same cycle
      if (set_inval) inval_r <= 1'b1;
      else if (clr_inval) inval_r <= 1'b0;
      if (teach) begin
        // In zone mode teaches alternate between the two thresholds
        if (out_mode == MD_ZONE && tph_r) begin
          thr2_r <= out_value;
          tph_r <= 1'b0;
        end else begin
          thr1_r <= out_value;
          tph_r <= out_mode == MD_ZONE;
        end
      end
      if (wb_wr && wr_ok) begin
        case (wb_adr_i)
          `MJO_A_CTRL: ctrl_r <= {19'h0, wdat[12:0]};
          `MJO_A_CLAMP: clamp_r <= wdat;
          `MJO_A_HOLD: hold_ms_r <= wdat[16:0];
          `MJO_A_THR1: thr1_r <= wdat;
          `MJO_A_THR2: thr2_r <= wdat;
          `MJO_A_HYST: hyst_r <= wdat;
          `MJO_A_TOL: tol_r <= wdat;
          `MJO_A_LIGHT: light_thr_r <= wdat[15:0];
          `MJO_A_EMIN: emin_r <= wdat;
          `MJO_A_EMAX: emax_r <= wdat;
          `MJO_A_LAG: lag_r <= wdat[4:0];
          `MJO_A_TIMER: timer_ms_r <= wdat[14:0];
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/mjo_map.vh ====
// Register offsets, field positions, reset values and timing for the judgment block
`ifndef MJO_MAP_VH
`define MJO_MAP_VH
`define MJO_A_CTRL 8'h00
`define MJO_A_CLAMP 8'h04
`define MJO_A_HOLD 8'h08
`define MJO_A_THR1 8'h0c
`define MJO_A_THR2 8'h10
`define MJO_A_HYST 8'h14
`define MJO_A_TOL 8'h18
`define MJO_A_LIGHT 8'h1c
`define MJO_A_EMIN 8'h20
`define MJO_A_EMAX 8'h24
`define MJO_A_LAG 8'h28
`define MJO_A_TIMER 8'h2c
`define MJO_A_CMD 8'h30
`define MJO_A_STAT 8'h34
`define MJO_A_VALUE 8'h38
`define MJO_A_EDGE 8'h3c
// Control word fields
`define MJO_F_ERR 1:0
`define MJO_F_MODE 4:2
`define MJO_F_FAR 5
`define MJO_F_DLY 8:6
`define MJO_F_DIR 10:9
`define MJO_F_REV 11
`define MJO_F_EHOLD 12
// Status bits
`define MJO_S_OUT 0
`define MJO_S_JUDGE 1
`define MJO_S_ALARM 2
`define MJO_S_INVAL 3
`define MJO_S_TPH 4
// Reset values (lengths in 0.1 mm units)
`define MJO_R_CTRL 32'h0000_0000
`define MJO_R_CLAMP 32'h0000_4e20
`define MJO_R_HOLD 17'h0_0001
`define MJO_R_LIGHT 16'h06a4
`define MJO_R_TIMER 15'h0001
`define MJO_R_LAG 5'h01
// Permitted ranges
`define MJO_CLAMP_MAX 32'sh0000_4e20
`define MJO_CLAMP_MIN -32'sh0000_4e20
`define MJO_HOLD_MAX 32'h0001_86a0
`define MJO_TIMER_MAX 32'h0000_7530
`define MJO_LAG_MAX 32'h0000_001f
// Timing: one millisecond tick at 5 ns clock
`define MJO_TICK_NS 1000000
`define MJO_CLK_NS 5
`endif

// ==== src/mjo_out_timer.v ====
// Delay and one-shot shaping of the switching judgment
`timescale 1ns/1ps
`default_nettype none
module mjo_out_timer (
  input wire ref_clk,
  input wire rst_b,
  input wire ms_tick,
  input wire judge,
  input wire [2:0] dly_mode,
  input wire [14:0] time_ms,
  output reg out_q
);
  localparam [2:0] DLY_OFF = 3'h0;
  localparam [2:0] DLY_ON = 3'h1;
  localparam [2:0] DLY_OFFD = 3'h2;
  localparam [2:0] DLY_BOTH = 3'h3;
  localparam [2:0] DLY_SHOT = 3'h4;
  reg [14:0] cnt_r;
  reg judge_d_r;
  reg shot_r;
  wire slow_edge;
  // Only the edges that this mode delays are counted; an edge it does not delay follows at once
  assign slow_edge = judge ? (dly_mode == DLY_ON || dly_mode == DLY_BOTH)
                           : (dly_mode == DLY_OFFD || dly_mode == DLY_BOTH);

  // Timer counts whole millisecond ticks and fires on the tick after the count reaches the set
  // time, so a delay or pulse is never shorter than set and at most one tick longer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= 1'b0;
      cnt_r <= 15'h0000;
      judge_d_r <= 1'b0;
      shot_r <= 1'b0;
    end else begin
      judge_d_r <= judge;
      case (dly_mode)
        DLY_OFF: begin
          out_q <= judge;
          cnt_r <= 15'h0000;
          shot_r <= 1'b0;
        end
        DLY_ON, DLY_OFFD, DLY_BOTH: begin
          shot_r <= 1'b0;
          if (judge == out_q) begin
            cnt_r <= 15'h0000;
          end else if (!slow_edge) begin
            out_q <= judge;
            cnt_r <= 15'h0000;
          end else if (ms_tick) begin
            if (cnt_r >= time_ms) begin
              out_q <= judge;
              cnt_r <= 15'h0000;
            end else begin
              cnt_r <= cnt_r + 15'h0001;
            end
          end
        end
        DLY_SHOT: begin
          // A rising judgment during the pulse is ignored, never extends it
          if (shot_r) begin
            if (ms_tick) begin
              if (cnt_r >= time_ms) begin
                out_q <= 1'b0;
                shot_r <= 1'b0;
                cnt_r <= 15'h0000;
              end else begin
                cnt_r <= cnt_r + 15'h0001;
              end
            end
          end else if (judge && !judge_d_r) begin
            out_q <= 1'b1;
            shot_r <= 1'b1;
            cnt_r <= 15'h0000;
          end else begin
            out_q <= 1'b0;
          end
        end
        default: begin
          out_q <= 1'b0;
          cnt_r <= 15'h0000;
          shot_r <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== testbench/mjo_field_input.sv ====
// Field input model reading the switching output
`timescale 1ns/1ps
`default_nettype none
module mjo_field_input (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic switch_output_one,
  output logic [15:0] rise_cnt_r,
  output logic [31:0] width_r
);
  logic [31:0] run_r;
  // Counts on-edges and keeps the last on-time, as a counting input card would
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_cnt_r <= 16'h0;
      width_r <= 32'h0;
      run_r <= 32'h0;
    end else begin
      run_r <= switch_output_one ? run_r + 32'h1 : 32'h0;
      if (switch_output_one && run_r == 32'h0) rise_cnt_r <= rise_cnt_r + 16'h1;
      if (!switch_output_one && run_r != 32'h0) width_r <= run_r;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/mjo_judge_assertions.sv ====
// Port-level checks for the judgment block
`timescale 1ns/1ps
`default_nettype none
`include "mjo_map.vh"
module mjo_judge_checker #(
  parameter TICK_CYC = 10
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic meas_valid,
  input wire logic signed [31:0] meas_value,
  input wire logic meas_alarm,
  input wire logic [15:0] light_level,
  input wire logic signed [31:0] out_value,
  input wire logic switch_output_one
);
  logic [31:0] ctrl_r, thr1_r, hyst_r, tmr_r, hi_r;
  logic signed [31:0] clamp_r;
  logic thr_ok_r;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire nodly = ctrl_r[`MJO_F_DLY] == 3'h0;
  wire mode0 = nodly && ctrl_r[`MJO_F_MODE] == 3'h0 && !ctrl_r[`MJO_F_FAR] && thr_ok_r;
  wire mode3 = nodly && ctrl_r[`MJO_F_MODE] == 3'h3;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Shadow of written settings; refused clamp and timer writes are skipped, other refused writes are taken, teach is not tracked
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= 32'h0;
      clamp_r <= 32'sh4e20;
      thr1_r <= 32'h0;
      hyst_r <= 32'h0;
      tmr_r <= 32'h1;
      hi_r <= 32'h0;
      thr_ok_r <= 1'b0;
    end else begin
      hi_r <= switch_output_one ? hi_r + 32'h1 : 32'h0;
      if (wr && wb_adr_i == `MJO_A_CTRL) ctrl_r <= wb_dat_i;
      if (wr && wb_adr_i == `MJO_A_HYST) hyst_r <= wb_dat_i;
      if (wr && wb_adr_i == `MJO_A_THR1) begin
        thr1_r <= wb_dat_i;
        thr_ok_r <= 1'b1;
      end
      if (wr && wb_adr_i == `MJO_A_CLAMP && $signed(wb_dat_i) >= `MJO_CLAMP_MIN && $signed(wb_dat_i) <= `MJO_CLAMP_MAX)
        clamp_r <= wb_dat_i;
      if (wr && wb_adr_i == `MJO_A_TIMER && wb_dat_i >= 32'h1 && wb_dat_i <= `MJO_TIMER_MAX) tmr_r <= wb_dat_i;
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_good;
    meas_valid && !meas_alarm;
  endsequence
  sequence s_bad;
    meas_valid && meas_alarm;
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_valid_passes: assert property (s_good |=> out_value == $past(meas_value))
    else $error("good sample not passed through");
  a_clamp_subst: assert property (s_bad ##0 ctrl_r[`MJO_F_ERR] == 2'h0 |=> out_value == clamp_r)
    else $error("clamp value not substituted");
  a_hold_keeps: assert property (s_bad ##0 ctrl_r[`MJO_F_ERR] == 2'h1 |=> $stable(out_value))
    else $error("held value changed");
  a_thr_on: assert property (s_good ##0 mode0 && meas_value >= $signed(thr1_r) |-> ##2 switch_output_one)
    else $error("output off above threshold");
  a_thr_off: assert property (s_good ##0 mode0 && meas_value < $signed(thr1_r) - $signed(hyst_r)
    |-> ##2 !switch_output_one)
    else $error("output on below release point");
  a_nomeas_follow: assert property (meas_valid && mode3
    |-> ##2 switch_output_one == ($past(meas_alarm, 2) ^ ctrl_r[`MJO_F_FAR]))
    else $error("output does not follow alarm");
  a_pulse_width: assert property ($fell(switch_output_one) && ctrl_r[`MJO_F_DLY] == 3'h4
    |-> hi_r + 32'h1 >= tmr_r * TICK_CYC && hi_r <= (tmr_r + 32'h1) * TICK_CYC + 32'h1)
    else $error("one-shot width off");
endmodule
bind mjo_judge_top mjo_judge_checker #(.TICK_CYC(TICK_CYC)) i_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .meas_valid(meas_valid), .meas_value(meas_value), .meas_alarm(meas_alarm),
  .light_level(light_level), .out_value(out_value), .switch_output_one(switch_output_one)
);
`default_nettype wire

// ==== testbench/mjo_judge_top_bench.sv ====
// Self-checking bench for the judgment block
`timescale 1ns/1ps
`default_nettype none
`include "mjo_map.vh"
module mjo_judge_top_bench;
  localparam int TK = 10;
  localparam logic [7:0] RA [6] = '{`MJO_A_CTRL, `MJO_A_CLAMP, `MJO_A_HOLD, `MJO_A_LIGHT, `MJO_A_TIMER, 8'h40};
  localparam logic [31:0] RV [6] = '{32'h0, 32'h4e20, 32'h1, 32'h6a4, 32'h1, 32'h0};
  localparam logic [7:0] GA [9] = '{`MJO_A_CLAMP, `MJO_A_CLAMP, `MJO_A_CLAMP, `MJO_A_HOLD, `MJO_A_HOLD,
    `MJO_A_HOLD, `MJO_A_TIMER, `MJO_A_TIMER, `MJO_A_TIMER};
  localparam logic [31:0] GD [9] = '{32'h4e21, 32'hffffb1e0, 32'hffffb1df, 32'h0, 32'h186a0, 32'h186a1,
    32'h7531, 32'h7530, 32'h0};
  localparam logic [31:0] GE [9] = '{32'h4e20, 32'hffffb1e0, 32'hffffb1e0, 32'h1, 32'h186a0, 32'h186a0,
    32'h1, 32'h7530, 32'h7530};
  localparam logic [31:0] SV [18] = '{32'h3e7, 32'h3e8, 32'h3c0, 32'h3b5, 32'h3e8, 32'h3b5, 32'h9c4, 32'h7c6,
    32'h79d, 32'h7c6, 32'h9c4, 32'hbd8, 32'hbf0, 32'h1450, 32'h13ec, 32'h1400, 32'h141f, 32'h1324};
  localparam logic [17:0] SE = 18'h12ce6;
  localparam logic [31:0] EC [5] = '{32'h14, 32'h214, 32'h414, 32'h814, 32'h1414};
  localparam logic [4:0] ER = 5'h15;
  localparam logic [4:0] EF = 5'h1e;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic meas_valid = 1'b0;
  logic meas_alarm = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic signed [31:0] meas_value = 32'sh0;
  logic [15:0] light_level = 16'hbb8;
  logic [31:0] wb_dat_o, rd, width_r;
  logic signed [31:0] out_value;
  logic [15:0] rise_cnt_r;
  logic wb_ack_o, switch_output_one;
  int mismatches = 0, comparisons = 0, cyc = 0, n, i;
  mjo_judge_top #(.TICK_CYC(TK)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .meas_valid(meas_valid), .meas_value(meas_value),
    .meas_alarm(meas_alarm), .light_level(light_level), .out_value(out_value),
    .switch_output_one(switch_output_one));
  mjo_field_input i_field (.ref_clk(ref_clk), .rst_b(rst_b), .switch_output_one(switch_output_one),
    .rise_cnt_r(rise_cnt_r), .width_r(width_r));
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Classic cycle: hold the request until ack is sampled, then release for a cycle
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask
  task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    chk(what, rd, exp);
  endtask
  // One sample strobe; returns three cycles after it is taken, once an undelayed switching output has settled
  task automatic smp(input logic [31:0] v, input logic al);
    @(posedge ref_clk);
    meas_valid <= 1'b1;
    meas_value <= v;
    meas_alarm <= al;
    @(posedge ref_clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic run(input int a, input int b);
    for (i = a; i <= b; i++) begin
      smp(SV[i], 1'b0);
      chk("switch output", switch_output_one, SE[i]);
    end
  endtask
  task automatic waitlvl(input logic lvl, input int lo, input int hi);
    n = 0;
    while (switch_output_one !== lvl && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    chk("switch delay", n >= lo && n <= hi, 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk("out_value", out_value, 32'h4e20);
    for (int k = 0; k < 6; k++) rdchk("reset value", RA[k], RV[k]);
    $display("reset values done");
    for (int k = 0; k < 9; k++) begin
      wr(GA[k], GD[k]);
      rdchk("range", GA[k], GE[k]);
    end
    xfer(1'b0, `MJO_A_STAT, 32'h0);
    chk("invalid flag", rd[`MJO_S_INVAL], 1'b1);
    wr(`MJO_A_STAT, 32'h8);
    xfer(1'b0, `MJO_A_STAT, 32'h0);
    chk("invalid flag", rd[`MJO_S_INVAL], 1'b0);
    // Two partial writes must merge into the word already stored
    wb_sel_i <= 4'h2;
    wr(`MJO_A_TOL, 32'habcd12ff);
    wb_sel_i <= 4'h1;
    wr(`MJO_A_TOL, 32'hffffff34);
    wb_sel_i <= 4'hf;
    rdchk("byte lanes", `MJO_A_TOL, 32'h1234);
    $display("range checks done");
    wr(`MJO_A_CLAMP, 32'hfffffb2e);
    smp(32'h1f4, 1'b0);
    smp(32'h9, 1'b1);
    chk("clamped", out_value, 32'hfffffb2e);
    wr(`MJO_A_CTRL, 32'h1);
    smp(32'h2bc, 1'b0);
    smp(32'h9, 1'b1);
    smp(32'h9, 1'b1);
    chk("held", out_value, 32'h2bc);
    wr(`MJO_A_HOLD, 32'h2);
    wr(`MJO_A_CTRL, 32'h2);
    smp(32'h320, 1'b0);
    smp(32'h9, 1'b1);
    chk("timed hold", out_value, 32'h320);
    repeat (40) @(posedge ref_clk);
    chk("hold expiry", out_value, 32'hfffffb2e);
    smp(32'h0, 1'b0);
    $display("error policy done");
    wr(`MJO_A_CTRL, 32'h0);
    wr(`MJO_A_HYST, 32'h32);
    wr(`MJO_A_THR1, 32'h3e8);
    // Start from a released output; the earlier zero sample had left it on
    smp(32'h0, 1'b0);
    run(0, 3);
    wr(`MJO_A_CTRL, 32'h20);
    run(4, 5);
    wr(`MJO_A_CTRL, 32'h4);
    smp(32'hbb8, 1'b0);
    wr(`MJO_A_CMD, 32'h1);
    smp(32'h7d0, 1'b0);
    wr(`MJO_A_CMD, 32'h1);
    rdchk("taught first", `MJO_A_THR1, 32'hbb8);
    rdchk("taught second", `MJO_A_THR2, 32'h7d0);
    run(6, 12);
    wr(`MJO_A_CTRL, 32'h8);
    wr(`MJO_A_THR1, 32'h1388);
    wr(`MJO_A_TOL, 32'h64);
    run(13, 17);
    wr(`MJO_A_CTRL, 32'h10);
    light_level <= 16'h6a3;
    smp(32'h0, 1'b0);
    chk("light low", switch_output_one, 1'b1);
    light_level <= 16'hbb8;
    smp(32'h0, 1'b0);
    chk("light good", switch_output_one, 1'b0);
    $display("judgment modes done");
    wr(`MJO_A_LAG, 32'h2);
    wr(`MJO_A_EMIN, 32'h64);
    wr(`MJO_A_EMAX, 32'h1f4);
    for (int k = 0; k < 5; k++) begin
      wr(`MJO_A_CTRL, EC[k]);
      repeat (20) smp(32'h0, 1'b0);
      smp(32'h12c, 1'b0);
      chk("edge rise", switch_output_one, ER[k]);
      repeat (20) smp(32'h12c, 1'b0);
      rdchk("edge value", `MJO_A_EDGE, k == 4 ? 32'h12c : 32'h0);
      smp(32'h0, 1'b0);
      chk("edge fall", switch_output_one, EF[k]);
    end
    $display("edge mode done");
    wr(`MJO_A_TIMER, 32'h3);
    for (int k = 0; k < 4; k++) begin
      wr(`MJO_A_CTRL, {23'h0, k[2:0], 6'h0c});
      smp(32'h0, 1'b1);
      waitlvl(1'b1, k[0] ? 25 : 0, k[0] ? 43 : 1);
      smp(32'h0, 1'b0);
      waitlvl(1'b0, k[1] ? 25 : 0, k[1] ? 43 : 1);
    end
    wr(`MJO_A_CTRL, 32'h10c);
    n = int'(rise_cnt_r);
    smp(32'h0, 1'b1);
    smp(32'h0, 1'b0);
    smp(32'h0, 1'b1);
    repeat (60) @(posedge ref_clk);
    chk("pulse end", switch_output_one, 1'b0);
    chk("pulse count", rise_cnt_r, n + 1);
    chk("pulse width", width_r >= 29 && width_r <= 41, 1'b1);
    smp(32'h0, 1'b0);
    $display("output timing done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
